// file: verilog/ufc_pkg.sv
// package for the uart feature configuration block
// register offsets, field positions, reset values and decode helpers
package ufc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_PIN_DIR = 4'h0;
   localparam logic [3:0] ADDR_PIN_LEVEL = 4'h1;
   localparam logic [3:0] ADDR_PIN_IRQ_EN = 4'h2;
   localparam logic [3:0] ADDR_PIN_FUNC = 4'h3;
   localparam logic [3:0] ADDR_EXTRA = 4'h4;
   localparam logic [3:0] ADDR_DIV_LOW = 4'h5;
   localparam logic [3:0] ADDR_DIV_HIGH = 4'h6;
   localparam logic [3:0] ADDR_FRAC = 4'h7;
   localparam logic [3:0] ADDR_ENH = 4'h8;
   localparam logic [3:0] ADDR_RESUME1 = 4'h9;
   localparam logic [3:0] ADDR_RESUME2 = 4'hA;
   localparam logic [3:0] ADDR_HALT1 = 4'hB;
   localparam logic [3:0] ADDR_HALT2 = 4'hC;

   // ----------------------------------------------------------------
   // field positions and writable masks
   // ----------------------------------------------------------------
   localparam int PFC_SOFT_RST = 3;
   localparam int PFC_CHB_SEL = 2;
   localparam int PFC_CHA_SEL = 1;
   localparam int PFC_LATCH = 0;
   localparam logic [7:0] PFC_MASK = 8'h07;
   localparam int EFC_IR_FAST = 7;
   localparam int EFC_POL = 5;
   localparam int EFC_HDX = 4;
   localparam int EFC_TX_DIS = 2;
   localparam int EFC_RX_DIS = 1;
   localparam int EFC_MDROP = 0;
   localparam logic [7:0] EFC_MASK = 8'hB7;
   localparam logic [7:0] FRAC_MASK = 8'h3F;
   localparam int FRAC_SAMP_HI = 5;
   localparam int FRAC_SAMP_LO = 4;
   localparam int ENH_ENABLE = 4;
   // modem pin positions inside a nibble
   localparam int MDM_RI = 3;
   localparam int MDM_CD = 2;
   localparam int MDM_DTR = 1;
   localparam int MDM_DSR = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DIV_LOW = 8'h01;

   // ----------------------------------------------------------------
   // types and decode
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      UFC_SAMP16 = 3'b001,
      UFC_SAMP8 = 3'b010,
      UFC_SAMP4 = 3'b100
   } ufc_samp_e;

   typedef enum logic [3:0] {
      UFC_FLOW_NONE = 4'b0001,
      UFC_FLOW_FIRST = 4'b0010,
      UFC_FLOW_SECOND = 4'b0100,
      UFC_FLOW_BOTH = 4'b1000
   } ufc_flow_e;

   // 10 first pair, 01 second pair, 11 both in sequence
   function automatic ufc_flow_e ufc_flow_decode(input logic [1:0] sel);
      case (sel)
         2'b10: ufc_flow_decode = UFC_FLOW_FIRST;
         2'b01: ufc_flow_decode = UFC_FLOW_SECOND;
         2'b11: ufc_flow_decode = UFC_FLOW_BOTH;
         default: ufc_flow_decode = UFC_FLOW_NONE;
      endcase
   endfunction : ufc_flow_decode

endpackage : ufc_pkg

// file: verilog/ufc_gpio_if.sv
// interface between the control logic and the pin stage
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface ufc_gpio_if;
   logic [7:0] level;
   logic [7:0] drive_val;
   logic [7:0] drive_en;
   modport ctrl (input level, output drive_val, output drive_en);
   modport pins (output level, input drive_val, input drive_en);
endinterface : ufc_gpio_if

// file: verilog/ufc_gpio.sv
// pin stage: input synchroniser and registered pin drivers
// assumes pin inputs are asynchronous to core_clk
`timescale 1ns/1ps
module ufc_gpio (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   // control side
   ufc_gpio_if.pins g
);
   import ufc_pkg::*;

   logic [7:0] sync_first;
   logic [7:0] sync_second;

   // ----------------------------------------------------------------
   // two flop synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync_first <= RST_ZERO;
         sync_second <= RST_ZERO;
      end else begin
         sync_first <= pin_in;
         sync_second <= sync_first;
      end
   end

   assign g.level = sync_second;

   // ----------------------------------------------------------------
   // drivers, all pins released during reset
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_out <= RST_ZERO;
         pin_oe_n <= 8'hFF;
      end else begin
         pin_out <= g.drive_val;
         pin_oe_n <= ~g.drive_en;
      end
   end

endmodule : ufc_gpio

// file: verilog/ufc_top.sv
// uart feature configuration: pin function, extra features, baud divisor
// and software flow control selection for a two channel uart
// assumes a single-cycle register port from the host serial slave logic
// and that the transmit/receive engines honour the control outputs
//
// Overview of operation
// R01 - soft reset bit clears modem selects, self-clears
// R02 - channel b select maps pins 3..0 to modem
// R03 - channel a select maps pins 7..4 to modem
// R04 - host sets terminal ready pin as output
// R05 - unlatched: change interrupts, read or return clears
// R06 - latched: change captured and held until read
// R07 - infrared bit picks 3/16 or 1/4 pulse
// R08 - half duplex bit makes rts the direction
// R09 - polarity bit inverts direction output level
// R10 - transmit disable stops after current shift character
// R11 - receive disable stops, current character completes
// R12 - multidrop bit selects 9-bit operation
// R13 - divisor is high:low plus fraction/16
// R14 - fraction register reachable only when enhanced enabled
// R15 - sampling field selects 16x, 8x or 4x
// R16 - transmit flow bits select characters sent
// R17 - receive flow bits select characters compared
// R18 - host clears flow bits before new setting
// R19 - enhanced enable gates writes, clear latches values
// R20 - level register reads pins, writes drive outputs
// R21 - reserved bits read zero, writes ignored
`timescale 1ns/1ps
module ufc_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // general purpose / modem pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   output logic pin_change_irq,
   // modem signals towards the channels
   input wire logic cha_terminal_ready_n,
   input wire logic chb_terminal_ready_n,
   output logic cha_ring_indicator_n,
   output logic cha_carrier_detect_n,
   output logic cha_set_ready_n,
   output logic chb_ring_indicator_n,
   output logic chb_carrier_detect_n,
   output logic chb_set_ready_n,
   output logic uart_soft_reset,
   // request-to-send path
   input wire logic tx_active,
   input wire logic rts_n_flow,
   output logic rts_n_pin,
   // controls towards the uart engines
   output logic ir_quarter_pulse,
   output logic tx_disable,
   output logic rx_disable,
   output logic multidrop_en,
   output logic [19:0] baud_divisor,
   output ufc_pkg::ufc_samp_e sample_rate,
   output ufc_pkg::ufc_flow_e tx_flow_sel,
   output ufc_pkg::ufc_flow_e rx_flow_sel,
   output logic [7:0] resume_char_first,
   output logic [7:0] resume_char_second,
   output logic [7:0] halt_char_first,
   output logic [7:0] halt_char_second
);
   import ufc_pkg::*;

   // ------------
   // registers and internal signals
   // ------------
   logic [7:0] pin_direction_register;
   logic [7:0] pin_level_out;
   logic [7:0] pin_irq_enable;
   logic [7:0] pin_function_control;
   logic [7:0] extra_feature_control;
   logic [7:0] baud_divisor_low;
   logic [7:0] baud_divisor_high;
   logic [7:0] baud_fraction_sampling;
   logic [7:0] enhanced_feature_select;
   logic [7:0] ref_level;
   logic [7:0] held_level;
   logic [7:0] held_pend;
   logic [7:0] change;
   logic [7:0] watched;
   logic [7:0] level_view;
   logic [7:0] next_rdata;
   logic [7:0] modem_pins;
   logic [7:0] next_drive_val;
   logic [7:0] next_drive_en;
   logic wr_en;
   logic rd_level;
   logic latch_mode;
   logic cha_modem;
   logic chb_modem;
   logic enh_open;

   ufc_gpio_if gif ();

   ufc_gpio u_gpio (
      .core_clk (core_clk),
      .rst_b (rst_b),
      .pin_in (pin_in),
      .pin_out (pin_out),
      .pin_oe_n (pin_oe_n),
      .g (gif.pins)
   );

   assign wr_en = reg_wr;
   assign rd_level = reg_rd && (reg_addr == ADDR_PIN_LEVEL);
   assign latch_mode = pin_function_control[PFC_LATCH];
   assign chb_modem = pin_function_control[PFC_CHB_SEL];
   assign cha_modem = pin_function_control[PFC_CHA_SEL];
   assign enh_open = enhanced_feature_select[ENH_ENABLE];

   // ------------
   // pin function control
   // ------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_function_control <= RST_ZERO;
      end else if (wr_en && reg_addr == ADDR_PIN_FUNC) begin
         if (reg_wdata[PFC_SOFT_RST]) begin
            // soft reset drops both modem selects; bit itself never stored
            pin_function_control <= {7'h00, reg_wdata[PFC_LATCH]}; // see R01
         end else begin
            pin_function_control <= reg_wdata & PFC_MASK; // see R21
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         uart_soft_reset <= 1'b0;
      end else begin
         uart_soft_reset <= wr_en && reg_addr == ADDR_PIN_FUNC && reg_wdata[PFC_SOFT_RST]; // see R01
      end
   end

   // ------------
   // direction, output level and interrupt enable
   // ------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_direction_register <= RST_ZERO;
         pin_level_out <= RST_ZERO;
         pin_irq_enable <= RST_ZERO;
      end else if (wr_en) begin
         if (reg_addr == ADDR_PIN_DIR) begin
            pin_direction_register <= reg_wdata;
         end
         if (reg_addr == ADDR_PIN_LEVEL) begin
            pin_level_out <= reg_wdata; // see R20
         end
         if (reg_addr == ADDR_PIN_IRQ_EN) begin
            pin_irq_enable <= reg_wdata;
         end
      end
   end

   // ------------
   // pin drive: gpio or modem per nibble
   // ------------
   always_comb begin
      next_drive_val = pin_level_out; // see R20
      next_drive_en = pin_direction_register;
      if (chb_modem) begin
         next_drive_val[3:0] = 4'h0;
         next_drive_val[MDM_DTR] = chb_terminal_ready_n; // see R02
         // only the terminal ready pin drives, and only once host set it output
         next_drive_en[3:0] = 4'h0;
         next_drive_en[MDM_DTR] = pin_direction_register[MDM_DTR]; // see R04
      end
      if (cha_modem) begin
         next_drive_val[7:4] = 4'h0;
         next_drive_val[4 + MDM_DTR] = cha_terminal_ready_n; // see R03
         next_drive_en[7:4] = 4'h0;
         next_drive_en[4 + MDM_DTR] = pin_direction_register[4 + MDM_DTR]; // see R04
      end
   end

   assign gif.drive_val = next_drive_val;
   assign gif.drive_en = next_drive_en;

   // ------------
   // modem inputs towards the channels, idle high when not selected
   // ------------
   assign modem_pins = gif.level;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         chb_ring_indicator_n <= 1'b1;
         chb_carrier_detect_n <= 1'b1;
         chb_set_ready_n <= 1'b1;
         cha_ring_indicator_n <= 1'b1;
         cha_carrier_detect_n <= 1'b1;
         cha_set_ready_n <= 1'b1;
      end else begin
         chb_ring_indicator_n <= chb_modem ? modem_pins[MDM_RI] : 1'b1; // see R02
         chb_carrier_detect_n <= chb_modem ? modem_pins[MDM_CD] : 1'b1; // see R02
         chb_set_ready_n <= chb_modem ? modem_pins[MDM_DSR] : 1'b1; // see R02
         cha_ring_indicator_n <= cha_modem ? modem_pins[4 + MDM_RI] : 1'b1; // see R03
         cha_carrier_detect_n <= cha_modem ? modem_pins[4 + MDM_CD] : 1'b1; // see R03
         cha_set_ready_n <= cha_modem ? modem_pins[4 + MDM_DSR] : 1'b1; // see R03
      end
   end

   // ------------
   // input change detection and latching
   // ------------
   // only gpio-mode input pins are watched
   assign watched = ~pin_direction_register & {{4{~cha_modem}}, {4{~chb_modem}}};
   assign change = (gif.level ^ ref_level) & watched;

   // latched bits show the captured value, others the live level
   always_comb begin
      level_view = gif.level;
      for (int i = 0; i < 8; i++) begin
         if (latch_mode && held_pend[i]) begin
            level_view[i] = held_level[i]; // see R06
         end
      end
   end

   // reference follows the value the host last saw
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ref_level <= RST_ZERO;
      end else if (rd_level) begin
         ref_level <= level_view; // see R05
      end
   end

   // a change in the read cycle is read live and becomes the new reference, so it does not re-arm
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         held_pend <= RST_ZERO;
         held_level <= RST_ZERO;
      end else if (!latch_mode || rd_level) begin
         held_pend <= RST_ZERO; // see R06
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (change[i] && !held_pend[i]) begin
               held_pend[i] <= 1'b1; // see R06
               held_level[i] <= gif.level[i]; // see R06
            end
         end
      end
   end

   // unlatched: pending is the live difference, so a return clears it
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_change_irq <= 1'b0;
      end else if (latch_mode) begin
         pin_change_irq <= |(held_pend & pin_irq_enable) && !rd_level; // see R06
      end else begin
         pin_change_irq <= |(change & pin_irq_enable) && !rd_level; // see R05
      end
   end

   // ------------
   // extra feature control and its outputs
   // ------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         extra_feature_control <= RST_ZERO;
      end else if (wr_en && reg_addr == ADDR_EXTRA) begin
         extra_feature_control <= reg_wdata & EFC_MASK; // see R21
      end
   end

   assign ir_quarter_pulse = extra_feature_control[EFC_IR_FAST]; // see R07
   // engine finishes the shifting character before idling
   assign tx_disable = extra_feature_control[EFC_TX_DIS]; // see R10
   // engine completes the character in progress into its fifo
   assign rx_disable = extra_feature_control[EFC_RX_DIS]; // see R11
   assign multidrop_en = extra_feature_control[EFC_MDROP]; // see R12

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rts_n_pin <= 1'b1;
      end else if (extra_feature_control[EFC_HDX]) begin
         // polarity 0: low while sending, high while listening
         rts_n_pin <= extra_feature_control[EFC_POL] ? tx_active : !tx_active; // see R08 see R09
      end else begin
         rts_n_pin <= rts_n_flow; // see R08
      end
   end

   // ------------
   // baud divisor and sampling rate
   // ------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         baud_divisor_low <= RST_DIV_LOW;
         baud_divisor_high <= RST_ZERO;
      end else if (wr_en) begin
         if (reg_addr == ADDR_DIV_LOW) begin
            baud_divisor_low <= reg_wdata;
         end
         if (reg_addr == ADDR_DIV_HIGH) begin
            baud_divisor_high <= reg_wdata;
         end
      end
   end

   // fraction writes only pass while enhanced functions are open
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         baud_fraction_sampling <= RST_ZERO;
      end else if (wr_en && reg_addr == ADDR_FRAC && enh_open) begin // see R14 see R19
         baud_fraction_sampling <= reg_wdata & FRAC_MASK; // see R21
      end
   end

   // 16.4 fixed point: integer above, sixteenths below
   assign baud_divisor = {baud_divisor_high, baud_divisor_low, baud_fraction_sampling[3:0]}; // see R13

   always_comb begin
      if (baud_fraction_sampling[FRAC_SAMP_HI]) begin
         sample_rate = UFC_SAMP4; // see R15
      end else if (baud_fraction_sampling[FRAC_SAMP_LO]) begin
         sample_rate = UFC_SAMP8; // see R15
      end else begin
         sample_rate = UFC_SAMP16; // see R15
      end
   end

   // ------------
   // enhanced feature select and flow characters
   // ------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         enhanced_feature_select <= RST_ZERO;
      end else if (wr_en && reg_addr == ADDR_ENH) begin
         enhanced_feature_select <= reg_wdata;
      end
   end

   assign tx_flow_sel = ufc_flow_decode(enhanced_feature_select[3:2]); // see R16
   assign rx_flow_sel = ufc_flow_decode(enhanced_feature_select[1:0]); // see R17

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         resume_char_first <= RST_ZERO;
         resume_char_second <= RST_ZERO;
         halt_char_first <= RST_ZERO;
         halt_char_second <= RST_ZERO;
      end else if (wr_en) begin
         if (reg_addr == ADDR_RESUME1) begin
            resume_char_first <= reg_wdata;
         end
         if (reg_addr == ADDR_RESUME2) begin
            resume_char_second <= reg_wdata;
         end
         if (reg_addr == ADDR_HALT1) begin
            halt_char_first <= reg_wdata;
         end
         if (reg_addr == ADDR_HALT2) begin
            halt_char_second <= reg_wdata;
         end
      end
   end

   // ------------
   // read back
   // ------------
   always_comb begin
      case (reg_addr)
         ADDR_PIN_DIR: next_rdata = pin_direction_register;
         ADDR_PIN_LEVEL: next_rdata = level_view; // see R20
         ADDR_PIN_IRQ_EN: next_rdata = pin_irq_enable;
         ADDR_PIN_FUNC: next_rdata = pin_function_control; // see R01
         ADDR_EXTRA: next_rdata = extra_feature_control;
         ADDR_DIV_LOW: next_rdata = baud_divisor_low;
         ADDR_DIV_HIGH: next_rdata = baud_divisor_high;
         ADDR_FRAC: next_rdata = enh_open ? baud_fraction_sampling : RST_ZERO; // see R14
         ADDR_ENH: next_rdata = enhanced_feature_select;
         ADDR_RESUME1: next_rdata = resume_char_first;
         ADDR_RESUME2: next_rdata = resume_char_second;
         ADDR_HALT1: next_rdata = halt_char_first;
         ADDR_HALT2: next_rdata = halt_char_second;
         default: next_rdata = RST_ZERO;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rdata <= RST_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule : ufc_top

// file: testbench/ufc_top_properties.sv
// checker for ufc_top: register side effects, rts path, change flag
// assumes one clock core_clk and synchronous active-low rst_b
`timescale 1ns/1ps
module ufc_checker (
   // clock and reset
   input logic core_clk,
   input logic rst_b,
   // register port
   input logic [3:0] reg_addr,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_wdata,
   // watched signals
   input logic pin_change_irq,
   input logic uart_soft_reset,
   input logic tx_active,
   input logic rts_n_flow,
   input logic rts_n_pin,
   input logic ir_quarter_pulse,
   input logic tx_disable,
   input logic rx_disable,
   input logic multidrop_en,
   input logic [19:0] baud_divisor,
   input ufc_pkg::ufc_samp_e sample_rate,
   input ufc_pkg::ufc_flow_e tx_flow_sel,
   input ufc_pkg::ufc_flow_e rx_flow_sel
);
   import ufc_pkg::*;
   logic [7:0] efc;
   logic [7:0] enh;
   // ------------
   // shadow copies of written controls
   // ------------
   always_ff @(posedge core_clk)
      if (!rst_b) efc <= 8'h00;
      else if (reg_wr && reg_addr == ADDR_EXTRA) efc <= reg_wdata;
   always_ff @(posedge core_clk)
      if (!rst_b) enh <= 8'h00;
      else if (reg_wr && reg_addr == ADDR_ENH) enh <= reg_wdata;
   function automatic ufc_flow_e fl(input logic [1:0] s);
      return s == 2'b00 ? UFC_FLOW_NONE : s == 2'b10 ? UFC_FLOW_FIRST : s == 2'b01 ? UFC_FLOW_SECOND : UFC_FLOW_BOTH;
   endfunction : fl
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   chk_soft_pulse: assert property (reg_wr && reg_addr == ADDR_PIN_FUNC && reg_wdata[PFC_SOFT_RST]
      |=> uart_soft_reset ##1 !uart_soft_reset) else $error("soft reset pulse");
   chk_extra_ctl: assert property (reg_wr && reg_addr == ADDR_EXTRA
      |=> {ir_quarter_pulse, tx_disable, rx_disable, multidrop_en} == {$past(reg_wdata[7]), $past(reg_wdata[2:0])})
      else $error("extra controls");
   chk_frac_lock: assert property (reg_wr && reg_addr == ADDR_FRAC && !enh[ENH_ENABLE]
      |=> $stable(baud_divisor[3:0])) else $error("fraction not locked");
   chk_samp_sel: assert property (reg_wr && reg_addr == ADDR_FRAC && enh[ENH_ENABLE]
      |=> sample_rate == ($past(reg_wdata[5]) ? UFC_SAMP4 : $past(reg_wdata[4]) ? UFC_SAMP8 : UFC_SAMP16))
      else $error("sampling rate");
   chk_flow_sel: assert property (reg_wr && reg_addr == ADDR_ENH
      |=> tx_flow_sel == fl($past(reg_wdata[3:2])) && rx_flow_sel == fl($past(reg_wdata[1:0])))
      else $error("flow select");
   chk_rts_dir: assert property (efc[EFC_HDX]
      |=> rts_n_pin == ($past(efc[EFC_POL]) ? $past(tx_active) : !$past(tx_active))) else $error("rts direction");
   chk_rts_flow: assert property (!efc[EFC_HDX]
      |=> rts_n_pin == $past(rts_n_flow)) else $error("rts flow path");
   chk_read_clr: assert property (reg_rd && reg_addr == ADDR_PIN_LEVEL
      |=> !pin_change_irq) else $error("flag not cleared by read");
endmodule : ufc_checker

// file: testbench/ufc_line_model.sv
// far-side line model: remote modem or station on the eight pins
// assumes far_level is what the remote end drives on undriven pins
`timescale 1ns/1ps
module ufc_line_model (
   // pins and remote drive
   input logic [7:0] pin_out,
   input logic [7:0] pin_oe_n,
   input logic [7:0] far_level,
   output logic [7:0] pin_in
);
   // device wins where it drives
   assign pin_in = (pin_out & ~pin_oe_n) | (far_level & pin_oe_n);
endmodule : ufc_line_model

// file: testbench/tb_uart_feature_config.sv
// testbench for ufc_top: register accesses, queued read checks, pin model
// assumes ufc_checker and ufc_line_model are compiled first
`timescale 1ns/1ps
module tb_uart_feature_config;
   import ufc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b, reg_wr, reg_rd, tx_active, rts_n_flow, cha_terminal_ready_n, chb_terminal_ready_n, pin_change_irq;
   logic cha_ring_indicator_n, cha_carrier_detect_n, cha_set_ready_n, chb_ring_indicator_n, chb_carrier_detect_n;
   logic chb_set_ready_n;
   logic rd_d = 1'b0;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, far_level, d, fc[4];
   logic [19:0] baud_divisor;
   logic [31:0] lf = 32'he8f7_b576;
   logic [11:0] exp_q[$];
   logic [11:0] e;
   int num_errors = 0;
   int checked = 0;
   ufc_top dut (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pin_in, .pin_out,
      .pin_oe_n, .pin_change_irq, .cha_terminal_ready_n, .chb_terminal_ready_n, .cha_ring_indicator_n,
      .cha_carrier_detect_n, .cha_set_ready_n, .chb_ring_indicator_n, .chb_carrier_detect_n, .chb_set_ready_n,
      .uart_soft_reset(), .tx_active, .rts_n_flow, .rts_n_pin(), .ir_quarter_pulse(), .tx_disable(),
      .rx_disable(), .multidrop_en(), .baud_divisor, .sample_rate(), .tx_flow_sel(), .rx_flow_sel(),
      .resume_char_first(fc[0]), .resume_char_second(fc[1]), .halt_char_first(fc[2]), .halt_char_second(fc[3]));
   ufc_line_model far (.pin_out, .pin_oe_n, .far_level, .pin_in);
   always #2.5 core_clk = ~core_clk;
   // ------------
   // tasks and result watcher
   // ------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic chk(input string n, input logic [19:0] seen, input logic [19:0] want);
      checked++;
      if (seen !== want) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, want, seen);
      end
   endtask : chk
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tk
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
      if (!w) exp_q.push_back({a, v});
      {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, v, w, !w};
      tk(1);
      {reg_wr, reg_rd} = 2'b00;
      tk(1);
   endtask : acc
   task automatic summarize();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   always @(posedge core_clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         chk($sformatf("reg %h", e[11:8]), 20'(reg_rdata), 20'(e[7:0]));
      end
      rd_d <= reg_rd;
   end
   always @(posedge core_clk) begin
      #1;
      lf = lfsr_next(lf);
      tx_active = lf[3];
      rts_n_flow = lf[9];
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      summarize();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, tx_active, rts_n_flow, cha_terminal_ready_n, chb_terminal_ready_n} = 7'h00;
      {reg_addr, reg_wdata, far_level} = 20'h0_0000;
      tk(20);
      rst_b = 1'b1;
      for (int a = 0; a < 16; a++) acc(0, 4'(a), (a == 5) ? RST_DIV_LOW : RST_ZERO);
      $display("test reset values done");
      d = lf[7:0];
      acc(1, ADDR_EXTRA, d);
      acc(0, ADDR_EXTRA, d & EFC_MASK);
      for (int p = 0; p < 3; p++) begin
         acc(1, ADDR_EXTRA, {2'b00, p != 0, p != 2, 4'h0});
         tk(12);
      end
      acc(1, ADDR_FRAC, 8'h0F);
      acc(0, ADDR_FRAC, 8'h00);
      acc(1, ADDR_ENH, 8'h10);
      acc(1, ADDR_DIV_LOW, d);
      acc(1, ADDR_DIV_HIGH, ~d);
      acc(1, ADDR_FRAC, 8'hC9);
      acc(0, ADDR_FRAC, 8'h09);
      chk("divisor", baud_divisor, {~d, d, 4'h9});
      acc(1, ADDR_ENH, 8'h00);
      acc(1, ADDR_FRAC, 8'h05);
      chk("divisor held", baud_divisor, {~d, d, 4'h9});
      acc(1, ADDR_ENH, 8'h10);
      for (int s = 0; s < 4; s++) acc(1, ADDR_FRAC, 8'(s << 4));
      for (int f = 0; f < 16; f++) begin
         acc(1, ADDR_ENH, 8'h10);
         acc(1, ADDR_ENH, 8'h10 | 8'(f));
         acc(0, ADDR_ENH, 8'h10 | 8'(f));
      end
      for (int c = 0; c < 4; c++) begin
         acc(1, ADDR_RESUME1 + 4'(c), d ^ 8'(c));
         chk("flow char", 20'(fc[c]), 20'(d ^ 8'(c)));
         acc(0, ADDR_RESUME1 + 4'(c), d ^ 8'(c));
      end
      $display("test divisor and flow done");
      far_level = 8'h03;
      acc(1, ADDR_PIN_DIR, 8'hF0);
      acc(1, ADDR_PIN_LEVEL, 8'hA5);
      chk("pin drive", 20'({pin_oe_n, pin_out[7:4]}), 20'h0_00FA);
      tk(3);
      acc(0, ADDR_PIN_LEVEL, 8'hA3);
      acc(1, ADDR_PIN_IRQ_EN, 8'h01);
      for (int m = 0; m < 2; m++) begin
         acc(1, ADDR_PIN_FUNC, 8'(m));
         far_level = 8'h02;
         tk(4);
         chk("flag raised", 20'(pin_change_irq), 20'h0_0001);
         far_level = 8'h03;
         tk(4);
         chk("flag after return", 20'(pin_change_irq), 20'(m));
      end
      acc(0, ADDR_PIN_LEVEL, 8'hA2);
      acc(1, ADDR_PIN_DIR, 8'h22);
      chb_terminal_ready_n = 1'b1;
      far_level = 8'h9C;
      acc(1, ADDR_PIN_FUNC, 8'h06);
      tk(3);
      chk("cha modem", 20'({cha_ring_indicator_n, cha_carrier_detect_n, cha_set_ready_n}), 20'h0_0005);
      chk("chb modem", 20'({chb_ring_indicator_n, chb_carrier_detect_n, chb_set_ready_n}), 20'h0_0006);
      chk("ready pins", 20'({pin_oe_n[5], pin_oe_n[1], pin_out[5], pin_out[1]}), 20'h0_0001);
      acc(1, ADDR_PIN_FUNC, 8'h08);
      tk(2);
      chk("soft reset", 20'({cha_carrier_detect_n, chb_set_ready_n}), 20'h0_0003);
      acc(0, ADDR_PIN_FUNC, 8'h00);
      $display("test pins done");
      summarize();
   end
endmodule : tb_uart_feature_config
bind ufc_top ufc_checker u_chk (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .pin_change_irq,
   .uart_soft_reset, .tx_active, .rts_n_flow, .rts_n_pin, .ir_quarter_pulse, .tx_disable, .rx_disable,
   .multidrop_en, .baud_divisor, .sample_rate, .tx_flow_sel, .rx_flow_sel);
